// file: hdl/jump_link_hazard_barrier_unit.sv
// Jump-and-link unit with delay slot, mode switch and hazard barrier
//
// Contract
// - barrier jump links PC plus 8
// - no compressed set: misaligned target faults
// - compressed set: mode from bit 0
// - bit0 clear, bit1 set faults
// - delay slot runs before target
// - hazards cleared before target fetch
// - hint bit 10 selects barrier
// - slot-created hazards stay pending
// - barrier allowed in every mode
// - jump in delay slot traps in Release 6 builds only
// - plain jump is link to zero
// - exchange links PC plus 8, mode bit
// - exchange target from index, slot region
// - exchange toggles mode after slot
// - exchange reserved without compressed set
// - exchange targets word aligned only
// - single set flag: full target kept
`timescale 1ns/1ps
`default_nettype none

module jump_link_hazard_barrier_unit #(
  parameter bit HAS_COMPRESSED = 1'b1,
  parameter bit RELEASE6 = 1'b0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic issue_valid,
  input wire logic [31:0] issue_instr,
  input wire logic [31:0] issue_pc,
  input wire logic issue_is_cti,
  input wire logic [31:0] source_value,
  input wire logic single_instr_set_flag,
  input wire logic hazard_create,
  input wire logic hazards_settled,
  output logic issue_ready,
  output logic jump_taken,
  output jlb_pkg::link_write_t link_write,
  output jlb_pkg::redirect_t redirect,
  output logic reserved_instr,
  output logic instr_set_mode_bit,
  output logic hazard_pending
);

  // Release 6 has no older compressed set; refuse that build
  if (RELEASE6 && HAS_COMPRESSED)
  begin : g_bad_build
    $error("Release 6 cannot carry the older compressed set");
  end

  // Idle, waiting for the delay slot, waiting for hazards to settle
  typedef enum logic [1:0] {
    st_idle,
    st_slot,
    st_settle
  } state_t;

  state_t state;
  state_t next_state;

  // Decoded view of the presented word
  jlb_pkg::decode_t dec;

  jlb_decode #(
    .HAS_COMPRESSED(HAS_COMPRESSED),
    .RELEASE6(RELEASE6)
  ) u_decode (
    .instr(issue_instr),
    .dec(dec)
  );

  // Held jump context
  logic [31:0] temp;
  logic [31:0] jump_pc;
  logic [25:0] index;
  logic is_region;
  logic barrier;

  // Hazards older than the jump versus created in or after its slot
  logic hazard_old;
  logic hazard_young;

  wire logic [31:0] tgt;
  wire logic tgt_mode;
  wire logic tgt_err;
  wire logic [31:0] slot_pc = jump_pc + jlb_pkg::SLOT_OFFSET;

  // Target, next mode and fetch fault from the held context, current mode and live single set flag
  jlb_target #(
    .HAS_COMPRESSED(HAS_COMPRESSED)
  ) u_target (
    .region(is_region),
    .temp(temp),
    .slot_pc(slot_pc),
    .index(index),
    .mode(instr_set_mode_bit),
    .single_instr_set_flag(single_instr_set_flag),
    .target(tgt),
    .next_mode(tgt_mode),
    .addr_error(tgt_err)
  );

  // Accept terms, all gated by the sequencer state
  // no privilege term in accept
  wire logic is_jump = dec.is_reg_jump || dec.is_region_exchange;
  wire logic accept_jump = issue_valid && (state == st_idle) && is_jump;
  wire logic reserved_now = issue_valid && (state == st_idle) && dec.reserved;
  wire logic slot_issue = issue_valid && (state == st_slot);
  // Transfer in the slot abandons the jump in Release 6 builds, no redirect
  // control transfer in slot
  wire logic slot_cti = slot_issue && issue_is_cti && RELEASE6;
  wire logic settle_done = (state == st_settle) && (!barrier || hazards_settled);
  wire logic fire = settle_done;

  // Link formed at accept from the jump's own PC
  // link is jump PC plus 8
  wire logic [31:0] link_base = issue_pc + jlb_pkg::LINK_OFFSET;
  wire logic [31:0] link_value = dec.is_region_exchange
    ? {link_base[31:1], instr_set_mode_bit} : link_base;
  wire logic link_en = accept_jump && (dec.dst != jlb_pkg::ZERO_REG);

  // Fetch may issue in idle and for the one slot instruction
  assign issue_ready = (state == st_idle) || (state == st_slot);

  // Sequencer: jump, exactly one slot issue, then redirect
  always_comb
  begin
    next_state = state;
    case (state)
      st_idle:
      begin
        if (accept_jump)
        begin
          next_state = st_slot;
        end
      end
      st_slot:
      begin
        if (slot_cti)
        begin
          next_state = st_idle;
        end
        else if (slot_issue)
        begin
          next_state = st_settle;
        end
      end
      st_settle:
      begin
        if (fire)
        begin
          next_state = st_idle;
        end
      end
      default:
      begin
        next_state = st_idle;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state <= st_idle;
    end
    else
    begin
      state <= next_state;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      temp <= '0;
      jump_pc <= '0;
      index <= '0;
      is_region <= 1'b0;
      barrier <= 1'b0;
    end
    else if (accept_jump)
    begin
      temp <= source_value;
      jump_pc <= issue_pc;
      index <= dec.index;
      is_region <= dec.is_region_exchange;
      barrier <= dec.barrier;
    end
  end

  // Link write pulses the cycle after accept
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      link_write <= '0;
    end
    else
    begin
      link_write.valid <= link_en;
      link_write.dst <= dec.dst;
      link_write.data <= link_value;
    end
  end

  // Redirect pulses once per completed jump
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      redirect <= '0;
    end
    else
    begin
      redirect.valid <= fire;
      redirect.target <= tgt;
      redirect.mode <= tgt_mode;
      redirect.addr_error <= tgt_err;
      redirect.hazard_clear <= fire && barrier;
    end
  end

  // Mode moves together with the redirect
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      instr_set_mode_bit <= jlb_pkg::MODE_RESET;
    end
    else if (fire)
    begin
      instr_set_mode_bit <= tgt_mode;
    end
  end

  // Reserved and taken pulses, one cycle each
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      reserved_instr <= 1'b0;
      jump_taken <= 1'b0;
    end
    else
    begin
      reserved_instr <= reserved_now || slot_cti;
      jump_taken <= accept_jump;
    end
  end

  wire logic young_phase = (state == st_slot) || (state == st_settle);
  wire logic clear_old = fire && barrier;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      hazard_old <= 1'b0;
      hazard_young <= 1'b0;
    end
    else if (clear_old)
    begin
      // Slot hazards become the new old set; set wins over clear
      hazard_old <= hazard_young || hazard_create;
      hazard_young <= 1'b0;
    end
    else if (young_phase)
    begin
      // Slot and settle hazards stay young
      hazard_young <= hazard_young || hazard_create;
    end
    else
    begin
      // In idle young hazards age into old
      hazard_old <= hazard_old || hazard_young || hazard_create;
      hazard_young <= 1'b0;
    end
  end

  assign hazard_pending = hazard_old || hazard_young;

endmodule

`default_nettype wire

// file: include/jlb_pkg.sv
// Shared constants and carriers for the jump, link and barrier unit
package jlb_pkg;

  localparam int unsigned XLEN = 32;
  localparam int unsigned REG_W = 5;
  localparam int unsigned INDEX_W = 26;

  // Instruction field positions
  localparam int unsigned OPC_HI = 31;
  localparam int unsigned OPC_LO = 26;
  localparam int unsigned RS_HI = 25;
  localparam int unsigned RS_LO = 21;
  localparam int unsigned RD_HI = 15;
  localparam int unsigned RD_LO = 11;
  localparam int unsigned HINT_BARRIER_BIT = 10;
  localparam int unsigned FUNC_HI = 5;
  localparam int unsigned FUNC_LO = 0;

  // Encodings
  localparam logic [5:0] OPC_REGISTER_FORMAT = 6'h00;
  localparam logic [5:0] OPC_REGION_EXCHANGE = 6'h1d;
  localparam logic [5:0] FUNC_REG_JUMP_LINK = 6'h09;

  localparam logic [REG_W-1:0] LINK_REG = 5'h1f;
  localparam logic [REG_W-1:0] ZERO_REG = 5'h00;

  // Link offset and region split
  localparam logic [XLEN-1:0] LINK_OFFSET = 32'h00000008;
  localparam logic [XLEN-1:0] SLOT_OFFSET = 32'h00000004;
  localparam int unsigned REGION_LO_W = 28;

  localparam logic MODE_RESET = 1'b0;

  typedef struct packed {
    logic is_reg_jump;
    logic barrier;
    logic is_region_exchange;
    logic reserved;
    logic [REG_W-1:0] src;
    logic [REG_W-1:0] dst;
    logic [INDEX_W-1:0] index;
  } decode_t;

  typedef struct packed {
    logic valid;
    logic [REG_W-1:0] dst;
    logic [XLEN-1:0] data;
  } link_write_t;

  typedef struct packed {
    logic valid;
    logic [XLEN-1:0] target;
    logic mode;
    logic addr_error;
    logic hazard_clear;
  } redirect_t;

endpackage

// file: hdl/jlb_decode.sv
// Decoder for the register jump-link and region jump-exchange forms
`timescale 1ns/1ps
`default_nettype none

module jlb_decode #(
  parameter bit HAS_COMPRESSED = 1'b1,
  parameter bit RELEASE6 = 1'b0
) (
  input wire logic [31:0] instr,
  output jlb_pkg::decode_t dec
);

  wire logic [5:0] opc = instr[jlb_pkg::OPC_HI:jlb_pkg::OPC_LO];
  wire logic [5:0] func = instr[jlb_pkg::FUNC_HI:jlb_pkg::FUNC_LO];
  wire logic reg_jump = (opc == jlb_pkg::OPC_REGISTER_FORMAT)
    && (func == jlb_pkg::FUNC_REG_JUMP_LINK);
  wire logic region = opc == jlb_pkg::OPC_REGION_EXCHANGE;
  wire logic region_bad = region && (!HAS_COMPRESSED || RELEASE6);

  assign dec.is_reg_jump = reg_jump;
  assign dec.barrier = reg_jump && instr[jlb_pkg::HINT_BARRIER_BIT];
  assign dec.is_region_exchange = region && !region_bad;
  assign dec.reserved = region_bad;
  assign dec.src = instr[jlb_pkg::RS_HI:jlb_pkg::RS_LO];
  assign dec.dst = region ? jlb_pkg::LINK_REG : instr[jlb_pkg::RD_HI:jlb_pkg::RD_LO];
  assign dec.index = instr[jlb_pkg::INDEX_W-1:0];

endmodule

`default_nettype wire

// file: hdl/jlb_target.sv
// Target address and mode for both jump forms, alignment check for the register form
`timescale 1ns/1ps
`default_nettype none

module jlb_target #(
  parameter bit HAS_COMPRESSED = 1'b1
) (
  input wire logic region,
  input wire logic [31:0] temp,
  input wire logic [31:0] slot_pc,
  input wire logic [25:0] index,
  input wire logic mode,
  input wire logic single_instr_set_flag,
  output logic [31:0] target,
  output logic next_mode,
  output logic addr_error
);

  wire logic plain = single_instr_set_flag || !HAS_COMPRESSED;
  wire logic [31:0] region_target = {slot_pc[31:jlb_pkg::REGION_LO_W], index, 2'b00};
  wire logic [31:0] reg_target = plain ? temp : {temp[31:1], 1'b0};
  wire logic reg_mode = plain ? mode : temp[0];
  wire logic reg_err = plain ? (temp[1:0] != 2'b00) : (!temp[0] && temp[1]);

  assign target = region ? region_target : reg_target;
  assign next_mode = region ? !mode : reg_mode;
  assign addr_error = region ? 1'b0 : reg_err;

endmodule

`default_nettype wire

// file: verification/jlb_props.sv
// Assertion checker for the jump link barrier unit
`timescale 1ns/1ps
`default_nettype none
module jlb_props #(
  parameter bit HAS_COMPRESSED = 1'b1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic issue_valid,
  input wire logic [31:0] issue_pc,
  input wire logic single_instr_set_flag,
  input wire logic hazards_settled,
  input wire logic issue_ready,
  input wire logic jump_taken,
  input wire jlb_pkg::link_write_t link_write,
  input wire jlb_pkg::redirect_t redirect,
  input wire logic reserved_instr,
  input wire logic instr_set_mode_bit
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  sequence no_redirect_2;
    !redirect.valid ##1 !redirect.valid;
  endsequence
  AST_TAKEN_ON_ACCEPT: assert property (jump_taken |-> $past(issue_valid && issue_ready))
    else $error("jump pulse without accept");
  AST_LINK_PC8: assert property (link_write.valid |->
    link_write.data[31:1] == (($past(issue_pc) + 32'h8) >> 1))
    else $error("link value not pc plus 8");
  AST_SLOT_FIRST: assert property (jump_taken |-> no_redirect_2)
    else $error("redirect before delay slot");
  AST_MODE_AT_REDIRECT: assert property (!$stable(instr_set_mode_bit) |-> redirect.valid)
    else $error("mode changed without redirect");
  AST_BIT0_CLEAR: assert property (HAS_COMPRESSED && redirect.valid && !single_instr_set_flag
    |-> !redirect.target[0])
    else $error("target bit 0 not cleared");
  AST_MISALIGN: assert property (redirect.valid && !redirect.mode && redirect.target[1]
    |-> redirect.addr_error)
    else $error("misaligned target without fault");
  AST_SETTLED: assert property (redirect.valid && redirect.hazard_clear
    |-> $past(hazards_settled))
    else $error("barrier redirect before settle");
  AST_RESERVED: assert property (reserved_instr |-> !link_write.valid && !redirect.valid)
    else $error("reserved with link or redirect");
endmodule
bind jump_link_hazard_barrier_unit jlb_props #(.HAS_COMPRESSED(HAS_COMPRESSED)) u_jlb_props (
  .clock(clock), .rst(rst), .issue_valid(issue_valid), .issue_pc(issue_pc),
  .single_instr_set_flag(single_instr_set_flag), .hazards_settled(hazards_settled),
  .issue_ready(issue_ready), .jump_taken(jump_taken), .link_write(link_write),
  .redirect(redirect), .reserved_instr(reserved_instr), .instr_set_mode_bit(instr_set_mode_bit));
`default_nettype wire

// file: verification/jlb_model.sv
// General register file model feeding the source operand
`timescale 1ns/1ps
`default_nettype none
module jlb_model (
  input wire logic clock,
  input wire logic [31:0] issue_instr,
  input wire jlb_pkg::link_write_t link_write,
  output logic [31:0] source_value
);
  logic [31:0] regs [32];
  always @(posedge clock)
  begin
    if (link_write.valid && link_write.dst != jlb_pkg::ZERO_REG)
      regs[link_write.dst] <= link_write.data;
  end
  assign source_value = regs[issue_instr[jlb_pkg::RS_HI:jlb_pkg::RS_LO]];
endmodule
`default_nettype wire

// file: verification/tb.sv
// Testbench for the jump link barrier unit
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic issue_valid = 1'b0;
  logic [31:0] issue_instr = 32'h0;
  logic [31:0] issue_pc = 32'h0;
  logic single_instr_set_flag = 1'b0;
  logic hazard_create = 1'b0;
  logic hazards_settled = 1'b1;
  logic issue_is_cti = 1'b0;
  logic issue_valid_r6 = 1'b0;
  logic ready_r6, taken_r6, reserved_r6, mode_r6;
  jlb_pkg::link_write_t link_r6;
  jlb_pkg::redirect_t redirect_r6;
  logic issue_ready, jump_taken, reserved_instr, instr_set_mode_bit, hazard_pending;
  logic [31:0] source_value;
  jlb_pkg::link_write_t link_write, lw;
  jlb_pkg::redirect_t redirect, rdr;
  int errors = 0;
  int num_checks = 0;
  int cyc = 0;
  always #5 clock = ~clock;
  jump_link_hazard_barrier_unit u_jump_link_hazard_barrier_unit (.clock(clock), .rst(rst),
    .issue_valid(issue_valid), .issue_instr(issue_instr), .issue_pc(issue_pc),
    .issue_is_cti(issue_is_cti), .source_value(source_value),
    .single_instr_set_flag(single_instr_set_flag), .hazard_create(hazard_create),
    .hazards_settled(hazards_settled), .issue_ready(issue_ready), .jump_taken(jump_taken),
    .link_write(link_write), .redirect(redirect), .reserved_instr(reserved_instr),
    .instr_set_mode_bit(instr_set_mode_bit), .hazard_pending(hazard_pending));
  // Release 6 build without the compressed set, for the reserved cases
  jump_link_hazard_barrier_unit #(.HAS_COMPRESSED(1'b0), .RELEASE6(1'b1))
    u_jump_link_hazard_barrier_unit_r6 (.clock(clock), .rst(rst), .issue_valid(issue_valid_r6),
    .issue_instr(issue_instr), .issue_pc(issue_pc), .issue_is_cti(issue_is_cti),
    .source_value(source_value), .single_instr_set_flag(single_instr_set_flag),
    .hazard_create(hazard_create), .hazards_settled(hazards_settled), .issue_ready(ready_r6),
    .jump_taken(taken_r6), .link_write(link_r6), .redirect(redirect_r6),
    .reserved_instr(reserved_r6), .instr_set_mode_bit(mode_r6), .hazard_pending());
  jlb_model u_jlb_model (.clock(clock), .issue_instr(issue_instr), .link_write(link_write),
    .source_value(source_value));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Jump, one slot, then wait for the redirect
  task automatic jump(input logic [31:0] ins, input logic [31:0] pc, input logic young);
    int i;
    @(negedge clock);
    issue_valid = 1'b1;
    issue_instr = ins;
    issue_pc = pc;
    hazards_settled = 1'b0;
    @(negedge clock);
    lw = link_write;
    chk({31'h0, jump_taken}, 32'h1);
    issue_instr = 32'h0;
    issue_pc = pc + 32'h4;
    hazard_create = young;
    @(negedge clock);
    issue_valid = 1'b0;
    hazard_create = 1'b0;
    chk({31'h0, issue_ready}, 32'h0);
    i = 0;
    while (redirect.valid !== 1'b1 && i < 20)
    begin
      hazards_settled = (i >= 2);
      i++;
      @(negedge clock);
    end
    rdr = redirect;
    hazards_settled = 1'b1;
    @(negedge clock);
  endtask
  task automatic res(input logic [31:0] vd, input logic [31:0] ld, input logic [31:0] tg,
    input logic [31:0] fl);
    chk({26'h0, lw.valid, lw.dst}, vd);
    if (vd[5])
      chk(lw.data, ld);
    chk(rdr.target, tg);
    chk({29'h0, rdr.mode, rdr.addr_error, rdr.hazard_clear}, fl);
  endtask
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      errors++;
      end_sim();
    end
  end
  initial
  begin
    for (int r = 0; r < 32; r++)
      u_jlb_model.regs[r] = 32'h0;
    u_jlb_model.regs[4] = 32'h10000001;
    u_jlb_model.regs[5] = 32'h20000002;
    u_jlb_model.regs[6] = 32'h50000001;
    repeat (16) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    hazard_create = 1'b1;
    @(negedge clock);
    hazard_create = 1'b0;
    @(negedge clock);
    chk({31'h0, hazard_pending}, 32'h1);
    jump(32'h00801c09, 32'h00000100, 1'b0);
    res(32'h23, 32'h00000108, 32'h10000000, 32'h5);
    chk({31'h0, hazard_pending}, 32'h0);
    chk({31'h0, instr_set_mode_bit}, 32'h1);
    $display("test barrier link done");
    jump(32'h74000123, 32'h3ffffffc, 1'b0);
    res(32'h3f, 32'h40000005, 32'h4000048c, 32'h0);
    chk({31'h0, instr_set_mode_bit}, 32'h0);
    $display("test exchange done");
    jump(32'h00a00409, 32'h00000180, 1'b1);
    res(32'h0, 32'h0, 32'h20000002, 32'h3);
    chk({31'h0, hazard_pending}, 32'h1);
    $display("test barrier jump done");
    single_instr_set_flag = 1'b1;
    jump(32'h00c03809, 32'h00000200, 1'b0);
    res(32'h27, 32'h00000208, 32'h50000001, 32'h2);
    chk(u_jlb_model.regs[7], 32'h00000208);
    $display("test single set done");
    // Release 6 build: exchange reserved, plain fault, slot transfer reserved
    issue_valid_r6 = 1'b1;
    issue_instr = 32'h74000123;
    issue_pc = 32'h00000300;
    @(negedge clock);
    chk({29'h0, reserved_r6, link_r6.valid, taken_r6}, 32'h4);
    issue_instr = 32'h00a01009;
    issue_pc = 32'h00000304;
    @(negedge clock);
    chk({30'h0, taken_r6, link_r6.valid}, 32'h3);
    chk(link_r6.data, 32'h0000030c);
    issue_instr = 32'h0;
    issue_pc = 32'h00000308;
    @(negedge clock);
    issue_valid_r6 = 1'b0;
    chk({31'h0, ready_r6}, 32'h0);
    @(negedge clock);
    chk(redirect_r6.target, 32'h20000002);
    chk({28'h0, redirect_r6.valid, redirect_r6.mode, redirect_r6.addr_error, mode_r6}, 32'ha);
    issue_valid_r6 = 1'b1;
    issue_instr = 32'h00a01009;
    issue_pc = 32'h00000400;
    @(negedge clock);
    issue_instr = 32'h0;
    issue_pc = 32'h00000404;
    issue_is_cti = 1'b1;
    @(negedge clock);
    issue_valid_r6 = 1'b0;
    issue_is_cti = 1'b0;
    chk({30'h0, reserved_r6, link_r6.valid}, 32'h2);
    @(negedge clock);
    chk({30'h0, redirect_r6.valid, ready_r6}, 32'h1);
    @(negedge clock);
    chk({31'h0, redirect_r6.valid}, 32'h0);
    $display("test release 6 reserved done");
    end_sim();
  end
endmodule
`default_nettype wire
